// ==== design/ebm_eisa_port.sv ====
// eisa bus master and io slave port with apb register access
//
// Local design decisions: the APB slave port and the address map.
`default_nettype none
module ebm_eisa_port
   import ebm_pkg::*;
#(
   parameter logic [9:2] IO_BASE = 8'h30
)(
   input  wire logic          ref_clk_i,
   input  wire logic          resetn_i,
   input  wire logic          psel_i,
   input  wire logic          penable_i,
   input  wire logic          pwrite_i,
   input  wire logic [7:0]    paddr_i,
   input  wire logic [31:0]   pwdata_i,
   output var  logic [31:0]   prdata_o,
   output var  logic          pready_o,
   output var  logic          pslverr_o,
   input  wire ebm_eisa_in_t  eisa_i,
   output var  ebm_eisa_out_t eisa_o
);
   // ==========================================
   // state
   typedef struct packed {
      ebm_eisa_in_t          s1;
      ebm_eisa_in_t          s2;
      logic                  bclk_d;
      ebm_mst_t              mst;
      ebm_eisa_out_t         o;
      logic                  hde;
      logic                  gie;
      logic                  lvl;
      logic                  dirw;
      logic                  run;
      logic [31:2]           addr;
      logic [COUNT_W-1:0]    count;
      logic [BACKOFF_W-1:0]  backoff;
      logic [BACKOFF_W-1:0]  bo_cnt;
      logic [31:0]           wdata;
      logic [31:0]           rdata;
      logic [IRQ_W-1:0]      pend;
      logic [IRQ_W-1:0]      ien;
      logic [7:0]            bc;
      logic                  burst_ok;
      logic                  preempt;
      logic [1:0]            gap;
      logic                  ex32_seen;
      logic                  io_sel;
      logic                  io_cmd;
      logic                  io_wr;
      logic [7:0]            io_wdat;
      logic [31:0]           prdata;
      logic                  pready;
      logic                  pslverr;
   } ebm_state_t;

   ebm_state_t r;
   ebm_state_t next_r;

   // ==========================================
   // helpers
   function automatic logic [31:2] drive_la(input logic [31:2] a);
      drive_la = {~a[31:24], a[23:2]};
   endfunction

   function automatic logic page_end(input logic [31:2] a);
      page_end = (a[9:2] == PAGE_WORD_MASK);
   endfunction

   function automatic logic [COUNT_W-1:0] count_down(input logic [COUNT_W-1:0] c);
      count_down = (c > BYTES_PER_WORD) ? c - BYTES_PER_WORD : '0;
   endfunction

   // ==========================================
   // next state
   logic                 rise;
   logic                 fall;
   logic                 owned;
   logic                 apb_setup;
   logic                 apb_write;
   logic                 xfer;
   logic                 term;
   logic                 irq_req;
   logic [IRQ_W-1:0]     ev;
   logic [IRQ_W-1:0]     clr;
   logic [COUNT_W-1:0]   cnt_after;

   always_comb
   begin
      next_r    = r;
      ev        = '0;
      clr       = '0;
      xfer      = 1'b0;
      next_r.s1 = eisa_i;
      next_r.s2 = r.s1;
      next_r.bclk_d = r.s2.bclk;
      rise      = r.s2.bclk & ~r.bclk_d;
      fall      = ~r.s2.bclk & r.bclk_d;
      owned     = (r.mst == M_ADDR) || (r.mst == M_START) || (r.mst == M_CMD) || (r.mst == M_BURST);
      apb_setup = psel_i & ~penable_i;
      apb_write = psel_i & penable_i & r.pready & pwrite_i & ~r.pslverr;
      cnt_after = count_down(r.count);

      // apb slave, zero wait states
      if (apb_setup)
      begin
         next_r.pready  = 1'b1;
         next_r.pslverr = 1'b0;
         next_r.prdata  = '0;
         unique case (paddr_i)
            REG_CTRL:
            begin
               next_r.prdata[CTL_HDE]  = r.hde;
               next_r.prdata[CTL_GIE]  = r.gie;
               next_r.prdata[CTL_LVL]  = r.lvl;
               next_r.prdata[CTL_DIRW] = r.dirw;
            end
            REG_ADDR:     next_r.prdata = {r.addr, 2'h0};
            REG_COUNT:    next_r.prdata[COUNT_W-1:0] = r.count;
            REG_BACKOFF:  next_r.prdata[BACKOFF_W-1:0] = r.backoff;
            REG_WDATA:    next_r.prdata = r.wdata;
            REG_RDATA:    next_r.prdata = r.rdata;
            REG_IRQ_PEND: next_r.prdata[IRQ_W-1:0] = r.pend;
            REG_IRQ_EN:   next_r.prdata[IRQ_W-1:0] = r.ien;
            REG_STATUS:
            begin
               next_r.prdata[ST_BUSY]    = (r.mst != M_IDLE);
               next_r.prdata[ST_OWN]     = owned;
               next_r.prdata[ST_BURST]   = ~r.o.msburst_n;
               next_r.prdata[ST_PREEMPT] = r.preempt;
               next_r.prdata[ST_BCEN]    = r.bc[BC_ENABLE];
               next_r.prdata[ST_EX32]    = r.ex32_seen;
               next_r.prdata[ST_RUN]     = r.run;
            end
            default:      next_r.pslverr = 1'b1;
         endcase
      end
      else if (psel_i & penable_i & r.pready)
      begin
         next_r.pready  = 1'b0;
         next_r.pslverr = 1'b0;
      end

      if (apb_write)
      begin
         unique case (paddr_i)
            REG_CTRL:
            begin
               next_r.hde  = pwdata_i[CTL_HDE];
               next_r.gie  = pwdata_i[CTL_GIE];
               next_r.lvl  = pwdata_i[CTL_LVL];
               next_r.dirw = pwdata_i[CTL_DIRW];
               if (pwdata_i[CTL_GO])
                  next_r.run = 1'b1;
            end
            REG_ADDR:     next_r.addr = pwdata_i[31:2];
            REG_COUNT:    next_r.count = pwdata_i[COUNT_W-1:0];
            REG_BACKOFF:  next_r.backoff = pwdata_i[BACKOFF_W-1:0];
            REG_WDATA:    next_r.wdata = pwdata_i;
            REG_IRQ_PEND: clr = pwdata_i[IRQ_W-1:0];
            REG_IRQ_EN:   next_r.ien = pwdata_i[IRQ_W-1:0];
            default:      next_r.ien = r.ien;
         endcase
      end

      // preemption and backoff
      if (owned & r.s2.mak_n & ~r.preempt)
      begin
         next_r.preempt = 1'b1;
         next_r.bo_cnt  = r.backoff;
         ev[IRQ_PREEMPT] = 1'b1;
      end
      else if (r.preempt & rise & (r.bo_cnt != '0))
         next_r.bo_cnt = r.bo_cnt - 1'b1;

      // a data transfer completes on a ready rising edge
      if (rise & r.s2.exrdy & ((r.mst == M_CMD) | (r.mst == M_BURST)))
      begin
         xfer = 1'b1;
         next_r.addr  = r.addr + 1'b1;
         next_r.count = cnt_after;
         next_r.ex32_seen = ~r.s2.ex32_n;
         if (~r.dirw)
            next_r.rdata = r.s2.d;
      end
      term = (cnt_after == '0) | ~r.hde | (r.preempt & (r.bo_cnt == '0));

      // master sequencer
      unique case (r.mst)
         M_IDLE:
            if (fall & r.run & r.bc[BC_ENABLE])
            begin
               next_r.o.mreq_n = 1'b0;
               next_r.mst      = M_REQ;
            end
         M_REQ:
            if (rise & ~r.s2.mak_n)
            begin
               next_r.o.la         = drive_la(r.addr);
               next_r.o.be_n       = 4'h0;
               next_r.o.mio        = 1'b1;
               next_r.o.master16_n = 1'b0;
               next_r.o.ctl_oe     = 1'b1;
               next_r.mst          = M_ADDR;
            end
         M_ADDR:
            if (rise)
            begin
               next_r.o.start_n = 1'b0;
               next_r.o.wr      = r.dirw;
               next_r.o.d       = r.wdata;
               next_r.o.d_oe    = r.dirw;
               next_r.mst       = M_START;
            end
         M_START:
            if (rise)
            begin
               next_r.o.start_n = 1'b1;
               next_r.burst_ok  = ~r.s2.slburst_n;
               next_r.mst       = M_CMD;
            end
         M_CMD:
         begin
            if (fall)
               next_r.burst_ok = 1'b0;
            if (fall & r.burst_ok & r.s2.exrdy & ~page_end(r.addr) & ~term)
               next_r.o.msburst_n = 1'b0;
            else if (xfer)
            begin
               next_r.o.la = drive_la(next_r.addr);
               if (term)
               begin
                  next_r.o.msburst_n = 1'b1;
                  next_r.mst         = M_RELEASE;
               end
               else if (~r.o.msburst_n)
                  next_r.mst = M_BURST;
               else
                  next_r.mst = M_ADDR;
            end
         end
         M_BURST:
            if (xfer)
            begin
               next_r.o.la = drive_la(next_r.addr);
               if (term | page_end(r.addr))
               begin
                  next_r.o.msburst_n = 1'b1;
                  next_r.mst         = term ? M_RELEASE : M_ADDR;
               end
            end
         M_RELEASE:
            if (fall)
            begin
               next_r.o.mreq_n     = 1'b1;
               next_r.o.ctl_oe     = 1'b0;
               next_r.o.d_oe       = 1'b0;
               next_r.o.mio        = 1'b0;
               next_r.o.wr         = 1'b0;
               next_r.o.master16_n = 1'b1;
               next_r.preempt      = 1'b0;
               next_r.gap          = '0;
               if ((r.count == '0) | ~r.hde)
               begin
                  next_r.run   = 1'b0;
                  ev[IRQ_DONE] = 1'b1;
               end
               next_r.mst = M_GAP;
            end
         M_GAP:
            if (fall)
            begin
               if (r.gap == GAP_BCLKS - 2'h1)
               begin
                  if (r.run & r.bc[BC_ENABLE])
                  begin
                     next_r.o.mreq_n = 1'b0;
                     next_r.mst      = M_REQ;
                  end
                  else
                     next_r.mst = M_IDLE;
               end
               else
                  next_r.gap = r.gap + 2'h1;
            end
         default:
            next_r.mst = M_IDLE;
      endcase

      // io slave
      if (~owned)
      begin
         if (~r.io_sel)
         begin
            if (~r.s2.start_n & ~r.s2.aen & ~r.s2.mio & (r.s2.la == IO_BASE) & ~r.s2.be_n[0])
            begin
               next_r.io_sel    = 1'b1;
               next_r.io_cmd    = 1'b0;
               next_r.io_wr     = r.s2.wr;
               next_r.o.nows_n  = 1'b0;
               next_r.o.nows_oe = r.bc[BC_ENABLE];
            end
         end
         else if (~r.s2.cmd_n)
         begin
            next_r.io_cmd  = 1'b1;
            next_r.io_wdat = r.s2.d[7:0];
            if (~r.io_wr)
            begin
               next_r.o.d    = {24'h000000, r.bc};
               next_r.o.d_oe = 1'b1;
            end
         end
         else if (r.io_cmd)
         begin
            if (r.io_wr)
               next_r.bc = r.io_wdat;
            next_r.io_sel    = 1'b0;
            next_r.io_cmd    = 1'b0;
            next_r.o.nows_n  = 1'b1;
            next_r.o.nows_oe = 1'b0;
            next_r.o.d_oe    = 1'b0;
         end
      end

      // drivers follow the enable bit
      next_r.o.mreq_oe = r.bc[BC_ENABLE];
      if (~r.bc[BC_ENABLE])
      begin
         next_r.o.ctl_oe = 1'b0;
         if (~r.io_sel)
            next_r.o.d_oe = 1'b0;
      end

      // interrupt request
      next_r.pend = (r.pend & ~clr) | ev;
      irq_req = r.gie & |(r.pend & r.ien);
      if (r.lvl)
      begin
         next_r.o.irq    = 1'b0;
         next_r.o.irq_oe = irq_req & r.bc[BC_ENABLE];
      end
      else
      begin
         next_r.o.irq    = irq_req;
         next_r.o.irq_oe = r.bc[BC_ENABLE];
      end
   end

   // ==========================================
   // registers
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         r <= '0;
         r.o.mreq_n     <= 1'b1;
         r.o.start_n    <= 1'b1;
         r.o.msburst_n  <= 1'b1;
         r.o.master16_n <= 1'b1;
         r.o.nows_n     <= 1'b1;
      end
      else
         r <= next_r;
   end

   // ==========================================
   // outputs
   assign prdata_o  = r.prdata;
   assign pready_o  = r.pready;
   assign pslverr_o = r.pslverr;
   assign eisa_o    = r.o;
endmodule // ebm_eisa_port
`default_nettype wire

// ==== design/ebm_pkg.sv ====
// shared constants and types for the bus master / io slave port
//
// Functional notes
// - hold request asserted until grant arrives
// - release request only on bus clock fall
// - two full bus clocks before re-requesting
// - at least one transfer per request
// - normal cycles first, burst after slave agrees
// - announce burst when slave accepts burst
// - page crossing forces one normal cycle
// - burst ends on count, disable, backoff
// - no-wait-state answer as io slave
// - start after address valid, one clock long
// - direction changes with start, held
// - io slave uses direction input
// - sample 32-bit acknowledge while mastering
// - irq needs global and per-source enable
// - edge mode drives high or low
// - level mode drives low or floats
// - reset disables drivers, clears registers
// - drivers off until enable set, except reads
// - io decode on address, enables, aen, mio
// - full address driven, top byte inverted
// - announce 16-bit downshift ability as master
// - memory indication asserted for memory cycles
// - ready low adds wait states
`default_nettype none
package ebm_pkg;
   // ==========================================
   // apb register map
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_ADDR     = 8'h04;
   localparam logic [7:0] REG_COUNT    = 8'h08;
   localparam logic [7:0] REG_BACKOFF  = 8'h0C;
   localparam logic [7:0] REG_WDATA    = 8'h10;
   localparam logic [7:0] REG_RDATA    = 8'h14;
   localparam logic [7:0] REG_IRQ_PEND = 8'h18;
   localparam logic [7:0] REG_IRQ_EN   = 8'h1C;
   localparam logic [7:0] REG_STATUS   = 8'h20;
   // ==========================================
   // field positions
   localparam int CTL_HDE  = 0;
   localparam int CTL_GIE  = 1;
   localparam int CTL_LVL  = 2;
   localparam int CTL_DIRW = 3;
   localparam int CTL_GO   = 4;
   localparam int IRQ_DONE    = 0;
   localparam int IRQ_PREEMPT = 1;
   localparam int IRQ_W       = 2;
   localparam int BC_ENABLE   = 0;
   localparam int ST_BUSY    = 0;
   localparam int ST_OWN     = 1;
   localparam int ST_BURST   = 2;
   localparam int ST_PREEMPT = 3;
   localparam int ST_BCEN    = 4;
   localparam int ST_EX32    = 5;
   localparam int ST_RUN     = 6;
   // ==========================================
   // widths and counts
   localparam int COUNT_W   = 16;
   localparam int BACKOFF_W = 8;
   localparam logic [COUNT_W-1:0] BYTES_PER_WORD = 16'h0004;
   localparam logic [1:0]         GAP_BCLKS      = 2'h2;
   localparam logic [7:0]         PAGE_WORD_MASK = 8'hFF;
   // ==========================================
   // types
   typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_START, M_CMD, M_BURST, M_RELEASE, M_GAP} ebm_mst_t;
   typedef struct packed {
      logic        bclk;
      logic        mak_n;
      logic        exrdy;
      logic        ex32_n;
      logic        slburst_n;
      logic        aen;
      logic        start_n;
      logic        cmd_n;
      logic        mio;
      logic        wr;
      logic [9:2]  la;
      logic [3:0]  be_n;
      logic [31:0] d;
   } ebm_eisa_in_t;
   typedef struct packed {
      logic        mreq_n;
      logic        mreq_oe;
      logic        start_n;
      logic        msburst_n;
      logic        master16_n;
      logic        ctl_oe;
      logic        mio;
      logic        wr;
      logic [31:2] la;
      logic [3:0]  be_n;
      logic [31:0] d;
      logic        d_oe;
      logic        nows_n;
      logic        nows_oe;
      logic        irq;
      logic        irq_oe;
   } ebm_eisa_out_t;
endpackage : ebm_pkg
`default_nettype wire

// ==== tb/ebm_eisa_port_props.sv ====
// assertion checker for the eisa port
`default_nettype none
module ebm_eisa_port_props
   import ebm_pkg::*;
#(
   parameter logic [9:2] IO_BASE = 8'h30
)(
   input wire logic          ref_clk_i,
   input wire logic          resetn_i,
   input wire ebm_eisa_in_t  eisa_i,
   input wire ebm_eisa_out_t eisa_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic       bclk_q;
   logic       granted;
   logic       started;
   logic [1:0] gap;
   logic [3:0] age;
   wire        req = eisa_o.mreq_oe && !eisa_o.mreq_n;
   wire        fall = bclk_q && !eisa_i.bclk;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   // ========
   // helpers
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         bclk_q  <= 1'b0;
         granted <= 1'b0;
         started <= 1'b0;
         gap     <= 2'h3;
         age     <= 4'hF;
      end
      else
      begin
         bclk_q  <= eisa_i.bclk;
         granted <= req && (granted || !eisa_i.mak_n);
         started <= req && (started || (eisa_o.ctl_oe && !eisa_o.start_n));
         gap     <= req ? 2'h0 : ((fall && gap != 2'h3) ? gap + 2'h1 : gap);
         age     <= fall ? 4'h0 : ((age != 4'hF) ? age + 4'h1 : age);
      end
   end
   // ========
   // properties
   a_req_hold: assert property (req && !granted |=> req)
      else $error("request dropped before grant");
   a_release_fall: assert property ($fell(req) |-> age <= 4'h5)
      else $error("request released away from a fall");
   a_regap_two: assert property ($rose(req) |-> gap >= 2'h2)
      else $error("request repeated too soon");
   a_one_xfer: assert property ($fell(req) |-> started)
      else $error("request released without a cycle");
   a_start_width: assert property ($fell(eisa_o.start_n) |-> !eisa_o.start_n [*7] ##[1:2] eisa_o.start_n)
      else $error("start width wrong");
   a_start_ready: assert property ($fell(eisa_o.start_n) |-> $past(eisa_o.ctl_oe) && eisa_o.mio && granted)
      else $error("start before address or grant");
   a_burst_slave: assert property ($fell(eisa_o.msburst_n) |-> eisa_o.ctl_oe && !eisa_i.slburst_n)
      else $error("burst without slave burst");
   a_owner_flags: assert property (eisa_o.ctl_oe |-> !eisa_o.master16_n && eisa_o.mio)
      else $error("owner flags wrong");
   a_nows_decode: assert property (!eisa_o.nows_n |-> !eisa_i.aen && !eisa_i.mio && eisa_i.la == IO_BASE)
      else $error("no wait state on foreign address");
   a_reset_quiet: assert property ($rose(resetn_i) |-> !(eisa_o.mreq_oe | eisa_o.ctl_oe | eisa_o.d_oe))
      else $error("drivers on after reset");
   c_burst: cover property ($fell(eisa_o.msburst_n));
   c_nows: cover property ($fell(eisa_o.nows_n));
   c_regap: cover property ($rose(req) && gap == 2'h2);
endmodule // ebm_eisa_port_props
bind ebm_eisa_port ebm_eisa_port_props #(.IO_BASE(IO_BASE)) ebm_eisa_port_props_i (
   .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .eisa_i(eisa_i), .eisa_o(eisa_o));
`default_nettype wire

// ==== tb/ebm_board_model.sv ====
// system board and memory slave model
`default_nettype none
module ebm_board_model
   import ebm_pkg::*;
(
   input  wire ebm_eisa_out_t dev_i,
   output var  ebm_eisa_in_t  bus_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic        bclk = 1'b0, mak_n = 1'b1, cmd_n = 1'b1, io_cmd_n = 1'b1, rdy = 1'b1, st_q = 1'b1;
   logic        io_act = 1'b0, io_start_n = 1'b1, io_wr = 1'b0, io_drv = 1'b0, burst_en = 1'b0, slow = 1'b0;
   logic        nows_seen = 1'b0, d_seen = 1'b0, ms_q = 1'b1;
   logic [9:2]  io_la = 8'h00;
   logic [31:0] io_d = 32'h0, last_d = 32'h0;
   logic [31:0] addr_q[$], d_q[$];
   logic        wr_q[$];
   int          starts = 0, bursts = 0, kick = 0;
   wire         own = dev_i.ctl_oe;
   wire [31:0]  dev_addr = {~dev_i.la[31:24], dev_i.la[23:2], 2'b00};
   initial
   begin
      #3;
      forever #40 bclk = ~bclk;
   end
   // ========
   // wire resolution
   always_comb
   begin
      bus_o.bclk      = bclk;
      bus_o.mak_n     = mak_n;
      bus_o.exrdy     = rdy;
      bus_o.ex32_n    = !own;
      bus_o.slburst_n = !(own && burst_en);
      bus_o.aen       = !io_act;
      bus_o.start_n   = own ? dev_i.start_n : io_start_n;
      bus_o.cmd_n     = cmd_n & io_cmd_n;
      bus_o.mio       = own ? dev_i.mio : !io_act;
      bus_o.wr        = own ? dev_i.wr : io_wr;
      bus_o.la        = own ? dev_i.la[9:2] : (io_act ? io_la : ~io_la);
      bus_o.be_n      = own ? dev_i.be_n : (io_act ? 4'hE : 4'hF);
      bus_o.d         = dev_i.d_oe ? dev_i.d : io_drv ? io_d : (own && !dev_i.wr) ? (dev_addr ^ 32'hA5A5_0000) : ~last_d;
   end
   // ========
   // arbiter and memory slave
   always @(negedge bclk) rdy <= slow ? !rdy : 1'b1;
   always @(posedge bclk)
   begin
      last_d <= bus_o.d;
      if (own && !cmd_n && rdy && (!dev_i.msburst_n || ms_q))
      begin
         addr_q.push_back(dev_addr);
         wr_q.push_back(dev_i.wr);
         d_q.push_back(bus_o.d);
         bursts += !dev_i.msburst_n;
      end
      if (own && !dev_i.start_n && st_q)
         starts++;
      st_q = dev_i.start_n | !own;
      ms_q = dev_i.msburst_n;
      // grant follows request; kick pulls the grant after that many transfers
      mak_n <= !(dev_i.mreq_oe && !dev_i.mreq_n) || (own && kick != 0 && addr_q.size() >= kick);
      if (own && !dev_i.start_n)
         cmd_n <= 1'b0;
      else if (rdy && dev_i.msburst_n)
         cmd_n <= 1'b1;
   end
   task automatic log_clear();
      addr_q.delete();
      d_q.delete();
      wr_q.delete();
      starts = 0;
      bursts = 0;
   endtask
   // ========
   // io cycle to the port
   task automatic io_cyc(input logic [9:2] a, input logic w, input logic [7:0] wd, output logic [7:0] rd);
      @(posedge bclk);
      io_act = 1'b1;
      io_la = a;
      io_wr = w;
      io_d = {24'h0, wd};
      @(posedge bclk);
      io_start_n = 1'b0;
      @(posedge bclk);
      io_start_n = 1'b1;
      io_cmd_n = 1'b0;
      io_drv = w;
      @(posedge bclk);
      nows_seen = dev_i.nows_oe && !dev_i.nows_n;
      d_seen = dev_i.d_oe;
      rd = bus_o.d[7:0];
      io_cmd_n = 1'b1;
      repeat (2) @(posedge bclk);
      io_drv = 1'b0;
      io_act = 1'b0;
   endtask
endmodule // ebm_board_model
`default_nettype wire

// ==== tb/ebm_eisa_port_tb_top.sv ====
// self-checking bench for the eisa port
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ebm_eisa_port_tb_top
   import ebm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic          ref_clk_i = 1'b0, resetn_i = 1'b0;
   logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [7:0]    paddr = 8'h00;
   logic [31:0]   pwdata = 32'h0, prdata;
   ebm_eisa_in_t  eisa_i;
   ebm_eisa_out_t eisa_o;
   int            err_count = 0, checked = 0;
   localparam logic [9:2] IO_BASE_T = 8'h30;
   always #5 ref_clk_i = ~ref_clk_i;
   ebm_eisa_port ebm_eisa_port_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .eisa_i(eisa_i), .eisa_o(eisa_o));
   ebm_board_model ebm_board_model_i (.dev_i(eisa_o), .bus_o(eisa_i));
   // ========
   // bus tasks
   task automatic close_out();
      $display("errors=%0d checks=%0d", err_count, checked);
      if (err_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [32:0] r);
      int n = 0;
      @(posedge ref_clk_i);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
      @(posedge ref_clk_i);
      penable <= 1'b1;
      do @(posedge ref_clk_i); while (pready !== 1'b1 && ++n < 50);
      r = {pslverr, prdata};
      {psel, penable} <= 2'b00;
      if (n >= 50)
      begin
         err_count++;
         close_out();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [32:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      logic [32:0] r;
      apb(1'b0, a, 32'h0, r);
      v = r[31:0];
   endtask
   task automatic run(input logic [31:0] a, input logic [31:0] n, input logic [31:0] c);
      logic [31:0] s;
      int k = 0;
      ebm_board_model_i.log_clear();
      wr(REG_ADDR, a);
      wr(REG_COUNT, n);
      wr(REG_CTRL, c | 32'h10);
      do rd(REG_STATUS, s); while ((s[ST_BUSY] | s[ST_RUN] | s[ST_OWN]) !== 1'b0 && ++k < 500);
      if (k >= 500)
      begin
         err_count++;
         close_out();
      end
   endtask
   // ========
   // scenarios
   task automatic s_reset();
      logic [32:0] r;
      apb(1'b0, REG_STATUS, 32'h0, r);
      `CHK(r, 33'h0)
      apb(1'b0, 8'h40, 32'h0, r);
      `CHK(r, 33'h1_0000_0000)
   endtask
   task automatic s_io_enable();
      logic [7:0]  r;
      logic [31:0] s;
      int drv = 0;
      repeat (80) @(posedge ref_clk_i) drv += eisa_o.mreq_oe | eisa_o.ctl_oe | eisa_o.nows_oe;
      `CHK(drv, 0)
      ebm_board_model_i.io_cyc(IO_BASE_T, 1'b0, 8'h00, r);
      `CHK({ebm_board_model_i.d_seen, r}, 9'h100)
      ebm_board_model_i.io_cyc(IO_BASE_T, 1'b1, 8'h01, r);
      `CHK(ebm_board_model_i.d_seen, 1'b0)
      ebm_board_model_i.io_cyc(IO_BASE_T, 1'b0, 8'h00, r);
      `CHK({ebm_board_model_i.nows_seen, r}, 9'h101)
      ebm_board_model_i.io_cyc(IO_BASE_T + 8'h01, 1'b1, 8'h00, r);
      rd(REG_STATUS, s);
      `CHK({ebm_board_model_i.nows_seen, s[ST_BCEN]}, 2'b01)
   endtask
   task automatic s_write_irq();
      ebm_board_model_i.slow = 1'b1;
      wr(REG_WDATA, 32'h1234_5678);
      wr(REG_IRQ_EN, 32'h1);
      run(32'hC000_0010, 32'h8, 32'h0B);
      `CHK(ebm_board_model_i.addr_q.size(), 2)
      `CHK({ebm_board_model_i.addr_q[0], ebm_board_model_i.addr_q[1]}, 64'hC000_0010_C000_0014)
      `CHK({ebm_board_model_i.wr_q[0], ebm_board_model_i.d_q[1]}, 33'h1_1234_5678)
      `CHK(ebm_board_model_i.starts, 2)
      `CHK({eisa_o.irq_oe, eisa_o.irq}, 2'b11)
      wr(REG_CTRL, 32'h01);
      repeat (2) @(posedge ref_clk_i);
      `CHK({eisa_o.irq_oe, eisa_o.irq}, 2'b10)
      wr(REG_CTRL, 32'h07);
      repeat (2) @(posedge ref_clk_i);
      `CHK({eisa_o.irq_oe, eisa_o.irq}, 2'b10)
      wr(REG_IRQ_PEND, 32'h1);
      repeat (2) @(posedge ref_clk_i);
      `CHK(eisa_o.irq_oe, 1'b0)
   endtask
   task automatic s_burst_page();
      logic [31:0] v;
      ebm_board_model_i.slow = 1'b0;
      ebm_board_model_i.burst_en = 1'b1;
      run(32'h0000_03F8, 32'h10, 32'h01);
      `CHK(ebm_board_model_i.addr_q.size(), 4)
      `CHK(ebm_board_model_i.addr_q[2], 32'h0000_0400)
      `CHK(ebm_board_model_i.starts, 2)
      `CHK(ebm_board_model_i.bursts > 0, 1'b1)
      rd(REG_RDATA, v);
      `CHK(v, 32'hA5A5_0404)
   endtask
   task automatic s_preempt();
      logic [31:0] v;
      ebm_board_model_i.burst_en = 1'b0;
      ebm_board_model_i.kick = 2;
      wr(REG_BACKOFF, 32'h2);
      run(32'h0000_0100, 32'h10, 32'h01);
      ebm_board_model_i.kick = 0;
      rd(REG_IRQ_PEND, v);
      `CHK(v, 32'h3)
      `CHK(ebm_board_model_i.addr_q.size(), 4)
      `CHK(ebm_board_model_i.addr_q[3], 32'h0000_010C)
   endtask
   initial
   begin
      repeat (16) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      s_reset();
      s_io_enable();
      s_write_irq();
      s_burst_page();
      s_preempt();
      close_out();
   end
endmodule // ebm_eisa_port_tb_top
`default_nettype wire
